// >>> design/byte_eeprom_access_ctrl.sv
// register controlled access to a 256 byte nonvolatile data store
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

// How it works
// (RULE1) 256 bytes, 8-bit address register selects one
// (RULE2) each write erases byte, then programs it
// (RULE3) internal timer sets the write duration
// (RULE4) protected store reads zeros to programmer
// (RULE5) read/write triggers set-only, hardware clears them
// (RULE6) write needs write_allow; cleared at power-up
// (RULE7) pin/watchdog reset mid-write sets abort flag
// (RULE8) reset clears address and data registers
// (RULE9) finished write sets write_done_flag; software clears
// (RULE10) unlock port stores nothing, reads zero
// (RULE11) control bits 7..4 read zero
// (RULE12) read trigger loads data next cycle
// (RULE13) data register holds until read or write
// (RULE14) 55h, AAh, write trigger in consecutive cycles
// (RULE15) write trigger refused unless write_allow set
// (RULE16) hardware never clears write_allow mid-write; here a pin/watchdog reset clears it, also mid-write
// (RULE17) writes blocked while power-up timer runs
// (RULE18) software leaves registers alone while writing

module byte_eeprom_access_ctrl
   import nv_pkg::*;
#(
   parameter int WRITE_CNT = WRITE_CYCLES,
   parameter int PWRT_CNT  = PWRT_CYCLES
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_pin_reset,
   input  wire logic       i_wdt_reset,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   output logic            o_write_busy,
   output logic            o_write_done_flag,
   input  wire logic       i_protect,
   input  wire logic [7:0] i_prog_addr,
   output logic      [7:0] o_prog_data
);

   // ----------------------------------------
   // storage and decode
   // ----------------------------------------
   localparam int ERASE_CNT = WRITE_CNT / 2;
   localparam int PROG_CNT  = WRITE_CNT - ERASE_CNT;

   logic [7:0] mem [256];
   state_s     st_reg;
   state_s     st_next;
   logic       mem_we;
   logic [7:0] mem_wa;
   logic [7:0] mem_wd;
   logic [7:0] rd_byte;
   logic       sys_reset;
   logic       wr_data_reg;
   logic       wr_addr_reg;
   logic       wr_ctrl;
   logic       wr_unlock;
   logic       wr_pflag;
   logic       write_start;
   logic       erase_end;
   logic       write_end;

   assign sys_reset   = i_pin_reset | i_wdt_reset;
   assign wr_data_reg = i_wr && (i_addr == DATA_OFF);
   assign wr_addr_reg = i_wr && (i_addr == ADDR_OFF);
   assign wr_ctrl     = i_wr && (i_addr == CTRL_OFF);
   assign wr_unlock   = i_wr && (i_addr == UNLOCK_OFF);
   assign wr_pflag    = i_wr && (i_addr == PFLAG_OFF);
   // (RULE1) full 8-bit address
   assign rd_byte     = mem[st_reg.address];

   // (RULE14) key steps then trigger
   // (RULE15) needs write_allow already set
   // (RULE6) write_allow gates every start
   // (RULE17) power-up timer must be done
   assign write_start = wr_ctrl && i_wdata[WR_BIT] && (st_reg.step == UNL_GOT_KEY2)
                        && st_reg.allow && st_reg.pwrt_done && !st_reg.wr;
   assign erase_end   = (st_reg.phase == PH_ERASE)
                        && (st_reg.timer == TIMER_W'(ERASE_CNT - 1));
   assign write_end   = (st_reg.phase == PH_PROGRAM)
                        && (st_reg.timer == TIMER_W'(PROG_CNT - 1));

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_next = st_reg;
      mem_we  = 1'b0;
      mem_wa  = st_reg.wr_addr;
      mem_wd  = st_reg.wr_data;

      // (RULE17) power-up write block
      if (!st_reg.pwrt_done)
      begin
         if (st_reg.pwrt_cnt == TIMER_W'(PWRT_CNT - 1))
            st_next.pwrt_done = 1'b1;
         else
            st_next.pwrt_cnt = st_reg.pwrt_cnt + 1'b1;
      end

      // (RULE13) data only moves on read, write or pin/watchdog reset
      // plain register writes
      if (wr_data_reg)
         st_next.data = i_wdata;
      if (wr_addr_reg)
         st_next.address = i_wdata;
      if (wr_ctrl)
      begin
         st_next.allow = i_wdata[ALLOW_BIT];
         st_next.abort = i_wdata[ABORT_BIT];
         // (RULE5) triggers can only be set
         if (i_wdata[RD_BIT])
            st_next.rd = 1'b1;
      end
      // (RULE9) software clears by writing zero
      if (wr_pflag && !i_wdata[DONE_BIT])
         st_next.done = 1'b0;

      // unlock sequencer: any break in the strict cadence drops back
      unique case (st_reg.step)
         UNL_IDLE:
            if (wr_unlock && (i_wdata == UNLOCK_KEY1))
               st_next.step = UNL_GOT_KEY1;
         UNL_GOT_KEY1:
            st_next.step = (wr_unlock && (i_wdata == UNLOCK_KEY2)) ? UNL_GOT_KEY2
                                                                   : UNL_IDLE;
         UNL_GOT_KEY2:
            st_next.step = UNL_IDLE;
      endcase

      // (RULE12) byte lands one cycle after trigger
      if (st_reg.rd)
      begin
         st_next.data = rd_byte;
         st_next.rd   = 1'b0;
      end

      // (RULE16) allow not consulted once running
      // latch target so later register edits cannot corrupt the write
      if (write_start)
      begin
         st_next.wr      = 1'b1;
         st_next.phase   = PH_ERASE;
         st_next.timer   = '0;
         st_next.wr_addr = st_reg.address;
         st_next.wr_data = st_reg.data;
      end

      // (RULE3) timed erase then program
      // (RULE2) erase happens first
      unique case (st_reg.phase)
         PH_IDLE:
            ;
         PH_ERASE:
            if (erase_end)
            begin
               mem_we        = 1'b1;
               mem_wd        = ERASED_BYTE;
               st_next.phase = PH_PROGRAM;
               st_next.timer = '0;
            end
            else
               st_next.timer = st_reg.timer + 1'b1;
         PH_PROGRAM:
            if (write_end)
            begin
               mem_we        = 1'b1;
               st_next.phase = PH_IDLE;
               // (RULE5) hardware clears write trigger
               st_next.wr    = 1'b0;
               // (RULE9) completion sets flag, set wins
               st_next.done  = 1'b1;
            end
            else
               st_next.timer = st_reg.timer + 1'b1;
         default:
            st_next.phase = PH_IDLE;
      endcase

      // (RULE7) reset mid-write aborts and flags it
      // (RULE8) address and data cleared
      if (sys_reset)
      begin
         if (st_reg.wr)
            st_next.abort = 1'b1;
         st_next.data    = ZERO_BYTE;
         st_next.address = ZERO_BYTE;
         st_next.rd      = 1'b0;
         st_next.wr      = 1'b0;
         st_next.allow   = 1'b0;
         st_next.step    = UNL_IDLE;
         st_next.phase   = PH_IDLE;
         st_next.timer   = '0;
         mem_we          = 1'b0;
      end

      // read port answers from current state
      st_next.rdata = ZERO_BYTE;
      if (i_rd)
      begin
         unique case (i_addr)
            DATA_OFF:  st_next.rdata = st_reg.data;
            ADDR_OFF:  st_next.rdata = st_reg.address;
            // (RULE11) upper control bits zero
            CTRL_OFF:  st_next.rdata = {4'h0, st_reg.abort, st_reg.allow,
                                        st_reg.wr, st_reg.rd};
            PFLAG_OFF: st_next.rdata = {st_reg.done, 7'h00};
            // (RULE10) unlock port has no storage
            default:   st_next.rdata = ZERO_BYTE;
         endcase
      end

      // (RULE4) protected store hides from programmer
      st_next.prog_data = i_protect ? ZERO_BYTE : mem[i_prog_addr];
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st_reg <= STATE_RESET;
      else
         st_reg <= st_next;
   end

   // array has no reset: contents are nonvolatile
   always_ff @(posedge i_clk)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end

   assign o_rdata           = st_reg.rdata;
   assign o_write_busy      = st_reg.wr;
   assign o_write_done_flag = st_reg.done;
   assign o_prog_data       = st_reg.prog_data;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [TIMER_W-1:0] busy_cnt;
   logic [7:0]         erased_byte;

   assign erased_byte = mem[st_reg.wr_addr];

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         busy_cnt <= '0;
      else if (st_reg.wr)
         busy_cnt <= busy_cnt + 1'b1;
      else
         busy_cnt <= '0;
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence start_seq;
      write_start && !sys_reset;
   endsequence

   sequence busy_seq;
      st_reg.wr && (st_reg.phase == PH_ERASE);
   endsequence

   sequence finish_seq;
      write_end && !sys_reset;
   endsequence

   read_load_a: assert property ( // RULE12
      (st_reg.rd && !sys_reset) |=> (st_reg.data == $past(rd_byte)) && !st_reg.rd)
      else $error("read trigger did not load data");

   start_ok_a: assert property ( // RULE14
      start_seq |=> busy_seq)
      else $error("write did not start after unlock");

   start_cause_a: assert property ( // RULE15
      $rose(st_reg.wr) |-> $past(st_reg.allow) && $past(st_reg.step) == UNL_GOT_KEY2)
      else $error("write started without allow and keys");

   pwrt_block_a: assert property ( // RULE17
      $rose(st_reg.wr) |-> $past(st_reg.pwrt_done))
      else $error("write started during power-up timer");

   write_len_a: assert property ( // RULE3
      finish_seq |-> busy_cnt == TIMER_W'(WRITE_CNT - 1))
      else $error("write duration wrong");

   done_flag_a: assert property ( // RULE9
      finish_seq |=> st_reg.done && !st_reg.wr)
      else $error("write completion not flagged");

   erase_first_a: assert property ( // RULE2
      $rose(st_reg.phase == PH_PROGRAM) && !$past(sys_reset) |-> erased_byte == ERASED_BYTE)
      else $error("byte not erased before program");

   trig_hold_a: assert property ( // RULE5
      (st_reg.wr && !write_end && !sys_reset) |=> st_reg.wr)
      else $error("write trigger cleared early");

   abort_set_a: assert property ( // RULE7
      (sys_reset && st_reg.wr) |=> st_reg.abort && !st_reg.wr)
      else $error("abort flag not set");

   clear_regs_a: assert property ( // RULE8
      sys_reset |=> st_reg.data == ZERO_BYTE && st_reg.address == ZERO_BYTE)
      else $error("reset did not clear registers");

   unlock_zero_a: assert property ( // RULE10
      (i_rd && i_addr == UNLOCK_OFF) |=> o_rdata == ZERO_BYTE)
      else $error("unlock port read not zero");

   ctrl_upper_a: assert property ( // RULE11
      (i_rd && i_addr == CTRL_OFF) |=> o_rdata[7:4] == 4'h0)
      else $error("control upper bits not zero");

   prot_zero_a: assert property ( // RULE4
      i_protect |=> o_prog_data == ZERO_BYTE)
      else $error("protected store visible to programmer");

   data_hold_a: assert property ( // RULE13
      (!st_reg.rd && !wr_data_reg && !sys_reset) |=> $stable(st_reg.data))
      else $error("data register changed on its own");

   allow_keep_a: assert property ( // RULE16
      (st_reg.allow && !wr_ctrl && !sys_reset) |=> st_reg.allow)
      else $error("hardware cleared write allow");

   allow_gate_a: assert property ( // RULE6
      (!st_reg.allow && !st_reg.wr) |=> !st_reg.wr)
      else $error("write ran without write allow");

endmodule

// >>> design/nv_pkg.sv
// shared constants and types of the byte storage access controller
package nv_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] PFLAG_OFF  = 8'h0C;
   localparam logic [7:0] DATA_OFF   = 8'h9A;
   localparam logic [7:0] ADDR_OFF   = 8'h9B;
   localparam logic [7:0] CTRL_OFF   = 8'h9C;
   localparam logic [7:0] UNLOCK_OFF = 8'h9D;

   // ----------------------------------------
   // field positions and keys
   // ----------------------------------------
   localparam int RD_BIT    = 0;
   localparam int WR_BIT    = 1;
   localparam int ALLOW_BIT = 2;
   localparam int ABORT_BIT = 3;
   localparam int DONE_BIT  = 7;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ       = 25;
   localparam int WRITE_TIME_US = 4;
   localparam int PWRT_MS       = 64;
   localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
   localparam int PWRT_CYCLES   = PWRT_MS * 1000 * CLK_MHZ;
   localparam int TIMER_W       = 21;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_KEY1, UNL_GOT_KEY2} unlock_e;
   typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_PROGRAM} phase_e;

   typedef struct packed {
      logic [7:0]         data;
      logic [7:0]         address;
      logic               rd;
      logic               wr;
      logic               allow;
      logic               abort;
      logic               done;
      unlock_e            step;
      phase_e             phase;
      logic [TIMER_W-1:0] timer;
      logic [7:0]         wr_addr;
      logic [7:0]         wr_data;
      logic [TIMER_W-1:0] pwrt_cnt;
      logic               pwrt_done;
      logic [7:0]         rdata;
      logic [7:0]         prog_data;
   } state_s;

   localparam state_s STATE_RESET = '{
      data: ZERO_BYTE, address: ZERO_BYTE, rd: 1'b0, wr: 1'b0, allow: 1'b0,
      abort: 1'b0, done: 1'b0, step: UNL_IDLE, phase: PH_IDLE, timer: '0,
      wr_addr: ZERO_BYTE, wr_data: ZERO_BYTE, pwrt_cnt: '0, pwrt_done: 1'b0,
      rdata: ZERO_BYTE, prog_data: ZERO_BYTE};

endpackage

// >>> verif/nv_prog_model.sv
// programmer side model that reads the store through its own port
`timescale 1ns/1ps

module nv_prog_model
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_req_protect,
   input  wire logic [7:0] i_req_addr,
   input  wire logic [7:0] i_prog_data,
   output logic            o_protect,
   output logic      [7:0] o_prog_addr,
   output logic      [7:0] o_seen
);
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_protect   <= 1'b0;
         o_prog_addr <= 8'h00;
         o_seen      <= 8'h00;
      end
      else
      begin
         o_protect   <= i_req_protect;
         o_prog_addr <= i_req_addr;
         o_seen      <= i_prog_data;
      end
   end
endmodule

// >>> verif/tb_byte_eeprom_access_ctrl.sv
// self-checking bench for the byte storage access controller
`timescale 1ns/1ps

module tb_byte_eeprom_access_ctrl;
   import nv_pkg::*;
   localparam int W = 10;
   logic       i_clk, i_rst, i_pin_reset, i_wdt_reset, i_wr, i_rd, i_protect;
   logic       o_write_busy, o_write_done_flag, req_protect;
   logic [7:0] i_addr, i_wdata, o_rdata, i_prog_addr, o_prog_data, req_addr, seen;
   int         n_errors, tests_run;

   byte_eeprom_access_ctrl #(.WRITE_CNT(W), .PWRT_CNT(20)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_pin_reset(i_pin_reset),
      .i_wdt_reset(i_wdt_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_write_busy(o_write_busy),
      .o_write_done_flag(o_write_done_flag), .i_protect(i_protect),
      .i_prog_addr(i_prog_addr), .o_prog_data(o_prog_data));

   nv_prog_model prog (
      .i_clk(i_clk), .i_rst(i_rst), .i_req_protect(req_protect),
      .i_req_addr(req_addr), .i_prog_data(o_prog_data), .o_protect(i_protect),
      .o_prog_addr(i_prog_addr), .o_seen(seen));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task end_sim;
      $display("errors=%0d comparisons=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk_b(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk_n(input int got, input int exp);
      tests_run++;
      if (got != exp)
      begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // strobe is left high so back-to-back writes keep adjacent cycles
   task wr(input logic [7:0] a, input logic [7:0] d);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
   endtask

   task idle;
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk_b(o_rdata, exp);
      @(posedge i_clk);
   endtask

   task seq(input logic [7:0] ctrl);
      wr(UNLOCK_OFF, UNLOCK_KEY1);
      wr(UNLOCK_OFF, UNLOCK_KEY2);
      wr(CTRL_OFF, ctrl);
   endtask

   // a refused start must leave busy low
   task try(input logic [7:0] k1, input logic [7:0] k2, input bit gap, input logic [7:0] c);
      wr(UNLOCK_OFF, k1);
      if (gap)
         idle();
      wr(UNLOCK_OFF, k2);
      wr(CTRL_OFF, c);
      idle();
      #1;
      chk_b({7'h00, o_write_busy}, 8'h00);
   endtask

   task run_write(input int exp);
      int n;
      n = 0;
      i_wr <= 1'b0;
      #1;
      while (o_write_busy === 1'b1 && n < 300)
      begin
         n++;
         @(posedge i_clk);
         #1;
      end
      if (n == 300)
      begin
         n_errors++;
         end_sim();
      end
      chk_n(n, exp);
      @(posedge i_clk);
   endtask

   task pulse(input bit wdt);
      if (wdt)
         i_wdt_reset <= 1'b1;
      else
         i_pin_reset <= 1'b1;
      @(posedge i_clk);
      i_wdt_reset <= 1'b0;
      i_pin_reset <= 1'b0;
      #1;
      chk_b({7'h00, o_write_busy}, 8'h00);
      @(posedge i_clk);
   endtask

   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      end_sim();
   end

   initial
   begin
      logic [7:0] regs [6];
      regs = '{DATA_OFF, ADDR_OFF, CTRL_OFF, UNLOCK_OFF, PFLAG_OFF, 8'h55};
      {i_rst, i_pin_reset, i_wdt_reset, i_wr, i_rd, req_protect} = 6'h20;
      {i_addr, i_wdata, req_addr} = 24'h000000;
      n_errors = 0;
      tests_run = 0;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 6; i++)
         rd(regs[i], 8'h00);
      wr(CTRL_OFF, 8'h04);
      try(UNLOCK_KEY1, UNLOCK_KEY2, 1'b0, 8'h06);
      repeat (24) @(posedge i_clk);
      wr(ADDR_OFF, 8'h05);
      wr(DATA_OFF, 8'h3C);
      seq(8'h06);
      run_write(W);
      rd(PFLAG_OFF, 8'h80);
      chk_b({7'h00, o_write_done_flag}, 8'h01);
      rd(CTRL_OFF, 8'h04);
      wr(DATA_OFF, 8'h00);
      wr(CTRL_OFF, 8'h05);
      idle();
      rd(DATA_OFF, 8'h3C);
      rd(CTRL_OFF, 8'h04);
      rd(DATA_OFF, 8'h3C);
      wr(PFLAG_OFF, 8'h00);
      rd(PFLAG_OFF, 8'h00);
      chk_b({7'h00, o_write_done_flag}, 8'h00);
      try(UNLOCK_KEY1, UNLOCK_KEY2, 1'b1, 8'h06);
      try(UNLOCK_KEY2, UNLOCK_KEY1, 1'b0, 8'h06);
      wr(CTRL_OFF, 8'h00);
      try(UNLOCK_KEY1, UNLOCK_KEY2, 1'b0, 8'h02);
      rd(CTRL_OFF, 8'h00);
      wr(CTRL_OFF, 8'h04);
      wr(ADDR_OFF, 8'hFF);
      wr(DATA_OFF, 8'hA5);
      seq(8'h06);
      wr(CTRL_OFF, 8'h00);
      run_write(W - 1);
      wr(CTRL_OFF, 8'h01);
      idle();
      rd(DATA_OFF, 8'hA5);
      req_addr <= 8'hFF;
      repeat (4) @(posedge i_clk);
      #1;
      chk_b(seen, 8'hA5);
      @(posedge i_clk);
      req_protect <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk_b(seen, 8'h00);
      @(posedge i_clk);
      for (int k = 0; k < 2; k++)
      begin
         wr(CTRL_OFF, 8'h04);
         wr(ADDR_OFF, 8'h10);
         wr(DATA_OFF, 8'h5A);
         seq(8'h06);
         idle();
         idle();
         pulse(k[0]);
         rd(CTRL_OFF, 8'h08);
         rd(ADDR_OFF, 8'h00);
         rd(DATA_OFF, 8'h00);
         wr(CTRL_OFF, 8'h04);
         wr(ADDR_OFF, 8'h10);
         wr(DATA_OFF, 8'h5A);
         seq(8'h06);
         run_write(W);
         rd(CTRL_OFF, 8'h04);
      end
      end_sim();
   end
endmodule
